// File: rtl/hbsc_defs.svh
// Constants of the H-bridge SPI control slave
`ifndef HBSC_DEFS_SVH
`define HBSC_DEFS_SVH

// ==========================================
// Serial word layout
`define HBSC_WORD_BITS 16
`define HBSC_CMD_WR_BIT 15
`define HBSC_ADDR_HI 14
`define HBSC_ADDR_LO 13
`define HBSC_ADDR_STATUS 2'h0
`define HBSC_ADDR_CONFIG 2'h1
`define HBSC_ADDR_MASK 2'h2

// ==========================================
// Reset values and fault input count
`define HBSC_SLEW_RST 3'h3
`define HBSC_MASK_RST 8'hFF
`define HBSC_FAULTS 8

// ==========================================
// Timing
`define HBSC_CLK_NS 20
`define HBSC_DEAD_NS 200
`define HBSC_DEAD_CYC ((`HBSC_DEAD_NS + `HBSC_CLK_NS - 1) / `HBSC_CLK_NS)

`endif

// File: rtl/hbsc_pkg.sv
// Types of the H-bridge SPI control slave
package hbsc_pkg;

	// ==========================================
	// Half-bridge leg states
	typedef enum logic [1:0] {
		LEG_OFF,
		LEG_DEAD,
		LEG_HIGH,
		LEG_LOW
	} hbsc_leg_type;

	// Leg state record
	typedef struct packed {
		hbsc_leg_type state;
		logic [7:0] deadCnt;
		logic hsOn;
		logic lsOn;
	} hbsc_legst_type;

	// Falling serial clock side
	typedef struct packed {
		logic [15:0] rxShift;
		logic [3:0] fallCnt;
		logic gotWord;
	} hbsc_fall_type;

	// Rising serial clock side
	typedef struct packed {
		logic [4:0] riseCnt;
		logic misoOut;
		logic misoOe;
	} hbsc_rise_type;

endpackage

// File: rtl/hbsc_leg.sv
// One half-bridge leg with break-before-make switching
`timescale 1ns/1ns
`default_nettype none

module hbsc_leg (
	input wire logic clk, // System clock
	input wire logic rstn, // Synchronous reset, active low
	input wire logic legEnable, // Leg may conduct
	input wire logic wantHigh, // Target: high side on
	input wire logic [7:0] deadCycles, // Both-off interval length
	output logic hsOn, // High-side switch on
	output logic lsOn // Low-side switch on
);
	import hbsc_pkg::*;

	hbsc_legst_type legReg;
	hbsc_legst_type legNext;

	// ==========================================
	// Next state
	always_comb begin
		legNext = legReg;
		unique case (legReg.state)
			LEG_OFF: begin
				if (legEnable) begin
					legNext.state = LEG_DEAD;
					legNext.deadCnt = deadCycles;
				end
			end
			LEG_DEAD: begin
				// Hold both switches off for the slew-derived time
				if (legReg.deadCnt > 8'h01) begin
					legNext.deadCnt = legReg.deadCnt - 8'h01;
				end else begin
					legNext.state = wantHigh ? LEG_HIGH : LEG_LOW;
				end
			end
			LEG_HIGH: begin
				if (!wantHigh) begin
					legNext.state = LEG_DEAD;
					legNext.deadCnt = deadCycles;
				end
			end
			LEG_LOW: begin
				if (wantHigh) begin
					legNext.state = LEG_DEAD;
					legNext.deadCnt = deadCycles;
				end
			end
		endcase
		// Disable overrides everything
		if (!legEnable) begin
			legNext.state = LEG_OFF;
		end
		// Outputs decode from one state, so never both on
		legNext.hsOn = (legNext.state == LEG_HIGH);
		legNext.lsOn = (legNext.state == LEG_LOW);
	end

	// State register
	always_ff @(posedge clk) begin
		if (!rstn) begin
			legReg <= '{LEG_OFF, 8'h00, 1'b0, 1'b0};
		end else begin
			legReg <= legNext;
		end
	end

	assign hsOn = legReg.hsOn;
	assign lsOn = legReg.lsOn;

endmodule

`default_nettype wire

// File: rtl/hbsc_top.sv
// H-bridge SPI control slave: serial port, registers and bridge steering
`timescale 1ns/1ns
`default_nettype none
`include "hbsc_defs.svh"

module hbsc_top #(
	parameter int FAULT_W = `HBSC_FAULTS // Number of fault inputs
) (
	input wire logic clk, // System clock, 50 MHz
	input wire logic rstn, // Synchronous reset, active low
	input wire logic spiClk, // Serial clock from master
	input wire logic chip_select_n, // Chip select, active low
	input wire logic mosi, // Serial data in
	output logic misoOut, // Serial data out level
	output logic misoOe, // Serial data out enable
	input wire logic sleep_enable_in, // Low puts device to sleep
	input wire logic output_disable_in, // High forces standby while awake
	input wire logic direction_in_a, // Steering of leg A
	input wire logic direction_in_b, // Steering of leg B
	input wire logic [FAULT_W-1:0] faultIn, // Fault conditions, high active
	output logic bridge_out_a_hs, // Leg A high-side on
	output logic bridge_out_a_ls, // Leg A low-side on
	output logic bridge_out_b_hs, // Leg B high-side on
	output logic bridge_out_b_ls, // Leg B low-side on
	output logic sleepState, // Device in sleep
	output logic standbyState, // Device in standby
	output logic [2:0] slewSel, // Current slew setting
	output logic fault_flag_n_out, // Fault flag level, always low
	output logic fault_flag_n_oe // Fault flag pulled low
);
	import hbsc_pkg::*;

	// ==========================================
	// Elaboration check
	if (FAULT_W < 1 || FAULT_W > 8) begin : gBadWidth
		$error("FAULT_W must lie between 1 and 8");
	end

	localparam int PIN_W = FAULT_W + 5;

	// System clock state
	typedef struct packed {
		logic [PIN_W-1:0] pinMeta;
		logic [PIN_W-1:0] pinSync;
		logic csnDly;
		logic [2:0] slew;
		logic [7:0] mask;
		logic [1:0] rdAddr;
		logic [15:0] txWord;
		logic flagOe;
		logic sleepSt;
		logic standbySt;
	} hbsc_core_type;

	hbsc_core_type coreReg;
	hbsc_core_type coreNext;
	hbsc_fall_type fallReg;
	hbsc_fall_type fallNext;
	hbsc_rise_type riseReg;
	hbsc_rise_type riseNext;
	logic firstFall;

	// Synchronised pin views
	logic csnS;
	logic sleepS;
	logic disS;
	logic dirAS;
	logic dirBS;
	logic [FAULT_W-1:0] faultS;
	logic [7:0] faultByte;
	logic commit;
	logic wordOk;
	logic [1:0] cmdAddr;
	logic [7:0] cmdData;
	logic legEnable;
	logic [7:0] deadCycles;

	// ==========================================
	// Falling serial clock: receive side
	// First falling edge of a frame restarts the bit count
	always_ff @(negedge spiClk or posedge chip_select_n) begin
		if (chip_select_n) begin
			firstFall <= 1'b1;
		end else begin
			firstFall <= 1'b0;
		end
	end

	// Shift in MOSI, first bit ends up most significant
	always_comb begin
		fallNext = fallReg;
		fallNext.rxShift = {fallReg.rxShift[14:0], mosi};
		if (firstFall) begin
			fallNext.fallCnt = 4'h1;
			fallNext.gotWord = 1'b0;
		end else begin
			fallNext.fallCnt = fallReg.fallCnt + 4'h1;
			fallNext.gotWord = fallReg.gotWord | (fallReg.fallCnt == 4'hF);
		end
	end

	// Clock edges arrive only inside a frame, so bits are taken only then
	always_ff @(negedge spiClk) begin
		fallReg <= fallNext;
	end

	// ==========================================
	// Rising serial clock: transmit side
	always_comb begin
		riseNext = riseReg;
		riseNext.misoOe = 1'b1;
		if (riseReg.riseCnt < 5'h10) begin
			// Word of the addressed register, most significant bit first
			riseNext.misoOut = coreReg.txWord[4'hF - riseReg.riseCnt[3:0]];
			riseNext.riseCnt = riseReg.riseCnt + 5'h01;
		end else begin
			// Bit taken sixteen clocks ago, for as long as clocks come
			riseNext.misoOut = fallReg.rxShift[15];
		end
	end

	// Chip select high ends the frame and floats MISO
	always_ff @(posedge spiClk or posedge chip_select_n) begin
		if (chip_select_n) begin
			riseReg <= '{5'h00, 1'b0, 1'b0};
		end else begin
			riseReg <= riseNext;
		end
	end

	// ==========================================
	// Pin views from the second synchroniser stage
	assign csnS = coreReg.pinSync[0];
	assign sleepS = coreReg.pinSync[1];
	assign disS = coreReg.pinSync[2];
	assign dirAS = coreReg.pinSync[3];
	assign dirBS = coreReg.pinSync[4];
	assign faultS = coreReg.pinSync[PIN_W-1:5];
	assign faultByte = 8'(faultS);

	// Frame end and word decode; receive state is quiet once select is high
	assign commit = csnS & ~coreReg.csnDly;
	// The receive record stays frozen once select is high, so it is read here without
	// the first-fall flag, which select high has already set again by commit time
	assign wordOk = fallReg.gotWord & (fallReg.fallCnt == 4'h0);
	assign cmdAddr = fallReg.rxShift[`HBSC_ADDR_HI:`HBSC_ADDR_LO];
	assign cmdData = fallReg.rxShift[7:0];

	// Bridge may conduct when awake and not disabled
	assign legEnable = sleepS & ~disS;

	// Dead interval grows with the slew field
	assign deadCycles = 8'(`HBSC_DEAD_CYC * (int'(coreReg.slew) + 1));

	// ==========================================
	// System clock next state
	always_comb begin
		coreNext = coreReg;
		coreNext.pinMeta = {faultIn, direction_in_b, direction_in_a,
			output_disable_in, sleep_enable_in, chip_select_n};
		coreNext.pinSync = coreReg.pinMeta;
		coreNext.csnDly = csnS;
		// Apply the received word at the select rising edge
		if (commit && wordOk) begin
			coreNext.rdAddr = cmdAddr;
			if (fallReg.rxShift[`HBSC_CMD_WR_BIT]) begin
				if (cmdAddr == `HBSC_ADDR_CONFIG) begin
					coreNext.slew = cmdData[2:0];
				end
				if (cmdAddr == `HBSC_ADDR_MASK) begin
					coreNext.mask = cmdData;
				end
			end
		end
		// Word for the next frame, frozen while selected
		if (csnS) begin
			case (coreNext.rdAddr)
				`HBSC_ADDR_STATUS: begin
					coreNext.txWord = {coreReg.sleepSt, coreReg.standbySt, 6'h00, faultByte};
				end
				`HBSC_ADDR_CONFIG: begin
					coreNext.txWord = {13'h0000, coreNext.slew};
				end
				`HBSC_ADDR_MASK: begin
					coreNext.txWord = {8'h00, coreNext.mask};
				end
				default: begin
					coreNext.txWord = 16'h0000;
				end
			endcase
		end
		// Masked fault flag
		coreNext.flagOe = |(faultByte & coreReg.mask);
		coreNext.sleepSt = ~sleepS;
		coreNext.standbySt = sleepS & disS;
	end

	// System clock register
	always_ff @(posedge clk) begin
		if (!rstn) begin
			// Select view resets to its idle high level, so no false commit follows reset
			coreReg <= '{{{(PIN_W-1){1'b0}}, 1'b1}, {{(PIN_W-1){1'b0}}, 1'b1}, 1'b1,
				`HBSC_SLEW_RST, `HBSC_MASK_RST,
				`HBSC_ADDR_STATUS, 16'h0000, 1'b0, 1'b1, 1'b0};
		end else begin
			coreReg <= coreNext;
		end
	end

	// ==========================================
	// Legs; direction input high selects high side
	hbsc_leg uLegA (
		.clk(clk),
		.rstn(rstn),
		.legEnable(legEnable),
		.wantHigh(dirAS),
		.deadCycles(deadCycles),
		.hsOn(bridge_out_a_hs),
		.lsOn(bridge_out_a_ls)
	);

	hbsc_leg uLegB (
		.clk(clk),
		.rstn(rstn),
		.legEnable(legEnable),
		.wantHigh(dirBS),
		.deadCycles(deadCycles),
		.hsOn(bridge_out_b_hs),
		.lsOn(bridge_out_b_ls)
	);

	// ==========================================
	// Outputs
	assign misoOut = riseReg.misoOut;
	assign misoOe = riseReg.misoOe;
	assign sleepState = coreReg.sleepSt;
	assign standbyState = coreReg.standbySt;
	assign slewSel = coreReg.slew;
	assign fault_flag_n_out = 1'b0; // Open drain: only the enable moves
	assign fault_flag_n_oe = coreReg.flagOe;

endmodule

`default_nettype wire

// File: tb/hbsc_assertions.sv
// Port checker of the H-bridge SPI control slave
`timescale 1ns/1ns
`default_nettype none
module hbsc_checker #(
	parameter int FAULT_W = 8 // Fault inputs
) (
	input wire logic clk, // System clock
	input wire logic rstn, // Reset, active low
	input wire logic spiClk, // Serial clock
	input wire logic chip_select_n, // Chip select
	input wire logic mosi, // Serial in
	input wire logic misoOut, // Serial out level
	input wire logic misoOe, // Serial out enable
	input wire logic sleep_enable_in, // Sleep when low
	input wire logic output_disable_in, // Standby when high and awake
	input wire logic direction_in_a, // Leg A steering
	input wire logic direction_in_b, // Leg B steering
	input wire logic [FAULT_W-1:0] faultIn, // Faults
	input wire logic bridge_out_a_hs, // Leg A high
	input wire logic bridge_out_a_ls, // Leg A low
	input wire logic bridge_out_b_hs, // Leg B high
	input wire logic bridge_out_b_ls, // Leg B low
	input wire logic sleepState, // Sleep
	input wire logic standbyState, // Standby
	input wire logic [2:0] slewSel, // Slew
	input wire logic fault_flag_n_out, // Flag level
	input wire logic fault_flag_n_oe // Flag pull
);
	logic [4:0] fallCnt;
	logic [15:0] hist;
	logic legsOff;
	// Falling edges of the frame and the MOSI bits they took
	always_ff @(negedge spiClk or posedge chip_select_n) begin
		if (chip_select_n) begin
			fallCnt <= 5'h00;
			hist <= 16'h0000;
		end else begin
			fallCnt <= (fallCnt == 5'h10) ? fallCnt : fallCnt + 5'h01;
			hist <= {hist[14:0], mosi};
		end
	end
	// All four switches off
	assign legsOff = !(bridge_out_a_hs | bridge_out_a_ls | bridge_out_b_hs | bridge_out_b_ls);
	property p_shootA;
		@(posedge clk) disable iff (!rstn) !(bridge_out_a_hs && bridge_out_a_ls);
	endproperty
	a_shootA: assert property (p_shootA) else $error("leg A both on");
	property p_shootB;
		@(posedge clk) disable iff (!rstn) !(bridge_out_b_hs && bridge_out_b_ls);
	endproperty
	a_shootB: assert property (p_shootB) else $error("leg B both on");
	property p_sleepOff;
		@(posedge clk) disable iff (!rstn) !sleep_enable_in [*4] |-> legsOff && sleepState;
	endproperty
	a_sleepOff: assert property (p_sleepOff) else $error("sleep leaves drive on");
	property p_disOff;
		@(posedge clk) disable iff (!rstn) output_disable_in [*4] |-> legsOff;
	endproperty
	a_disOff: assert property (p_disOff) else $error("disable leaves drive on");
	property p_standby;
		@(posedge clk) disable iff (!rstn) (sleep_enable_in && output_disable_in) [*4] |-> standbyState;
	endproperty
	a_standby: assert property (p_standby) else $error("standby not shown");
	property p_deadA;
		@(posedge clk) disable iff (!rstn) $fell(bridge_out_a_hs) |-> !bridge_out_a_ls [*8];
	endproperty
	a_deadA: assert property (p_deadA) else $error("leg A no off gap");
	property p_flagQuiet;
		@(posedge clk) disable iff (!rstn) (faultIn == {FAULT_W{1'b0}}) [*4] |-> !fault_flag_n_oe;
	endproperty
	a_flagQuiet: assert property (p_flagQuiet) else $error("flag without fault");
	property p_hiZ;
		@(posedge clk) disable iff (!rstn) chip_select_n |-> !misoOe;
	endproperty
	a_hiZ: assert property (p_hiZ) else $error("MISO driven unselected");
	property p_drive;
		@(negedge spiClk) disable iff (chip_select_n) misoOe;
	endproperty
	a_drive: assert property (p_drive) else $error("MISO not driven in frame");
	property p_echo;
		@(negedge spiClk) disable iff (chip_select_n) fallCnt == 5'h10 |-> misoOut == hist[15];
	endproperty
	a_echo: assert property (p_echo) else $error("MISO echo wrong");
endmodule
`default_nettype wire

// File: tb/hbsc_spi_master.sv
// Host serial master model
`timescale 1ns/1ns
`default_nettype none
module hbsc_spi_master (
	output logic spiClk, // Serial clock, idles low
	output logic chip_select_n, // Chip select
	output logic mosi, // Serial data out
	input wire logic misoOut, // Slave data level
	input wire logic misoOe // Slave data enable
);
	// Idle lines
	initial begin
		spiClk = 1'b0;
		chip_select_n = 1'b0;
		mosi = 1'b0;
		// A rising select edge clears the serial state before any frame
		#5 chip_select_n = 1'b1;
	end
	// One frame of n bits, first bit most significant
	task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
		rx = 32'h0000_0000;
		#37 chip_select_n = 1'b0;
		#90;
		for (int k = n - 1; k >= 0; k--) begin
			spiClk = 1'b1;
			mosi = tx[k];
			#62 spiClk = 1'b0;
			rx[k] = misoOe ? misoOut : 1'bx;
			#63;
		end
		#40 chip_select_n = 1'b1;
		mosi = ~mosi; // Released line shows no stale value
		#250;
	endtask
endmodule
`default_nettype wire

// File: tb/hbsc_tb_top.sv
// Testbench top of the H-bridge SPI control slave
`timescale 1ns/1ns
`default_nettype none
module hbsc_tb_top;
	logic clk, rstn, spiClk, csN, mosi, misoOut, misoOe, sleepEn, outDis, dirA, dirB;
	logic aHs, aLs, bHs, bLs, sleepSt, standbySt, flagOut, flagOe;
	logic [7:0] faults;
	logic [2:0] slew;
	logic [31:0] rx;
	int nFail, checks, n;
	hbsc_top DUT (.clk(clk), .rstn(rstn), .spiClk(spiClk), .chip_select_n(csN), .mosi(mosi),
		.misoOut(misoOut), .misoOe(misoOe), .sleep_enable_in(sleepEn), .output_disable_in(outDis),
		.direction_in_a(dirA), .direction_in_b(dirB), .faultIn(faults), .bridge_out_a_hs(aHs),
		.bridge_out_a_ls(aLs), .bridge_out_b_hs(bHs), .bridge_out_b_ls(bLs), .sleepState(sleepSt),
		.standbyState(standbySt), .slewSel(slew), .fault_flag_n_out(flagOut), .fault_flag_n_oe(flagOe));
	hbsc_spi_master host (.spiClk(spiClk), .chip_select_n(csN), .mosi(mosi), .misoOut(misoOut),
		.misoOe(misoOe));
	// 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Compare and count
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			nFail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic giveVerdict();
		$display("Comparisons %0d mismatches %0d", checks, nFail);
		if (nFail == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Bounded wait for a leg A switch level, n counts cycles
	task automatic waitLeg(input logic hs, input logic lvl);
		n = 0;
		while (((hs ? aHs : aLs) !== lvl) && n < 300) begin
			@(negedge clk);
			n++;
		end
		if (n >= 300) begin
			nFail++;
			giveVerdict();
		end
	endtask
	// Main sequence
	initial begin
		{rstn, outDis, dirA, dirB, faults} = '0;
		sleepEn = 1'b1;
		repeat (12) @(negedge clk);
		chk("reset slew", slew, 3'h3);
		chk("reset legs", {aHs, aLs, bHs, bLs}, 4'h0);
		rstn = 1'b1;
		repeat (6) @(negedge clk);
		host.xfer(32, 32'h5A5A_A005, rx);
		chk("status word", rx[31:16], 16'h0000);
		chk("echo word", rx[15:0], 16'h5A5A);
		chk("slew write", slew, 3'h5);
		chk("miso off", misoOe, 1'b0);
		host.xfer(16, 32'h0000_2000, rx);
		chk("config read", rx[15:0], 16'h0005);
		host.xfer(8, 32'h0000_00A7, rx);
		chk("short frame", slew, 3'h5);
		$display("Serial tests done");
		@(negedge clk);
		dirA = 1'b1;
		waitLeg(1'b1, 1'b1);
		dirA = 1'b0;
		waitLeg(1'b1, 1'b0);
		waitLeg(1'b0, 1'b1);
		chk("dead cycles", n, 60);
		sleepEn = 1'b0;
		repeat (5) @(negedge clk);
		chk("sleep legs", {aHs, aLs, bHs, bLs}, 4'h0);
		chk("sleep state", sleepSt, 1'b1);
		sleepEn = 1'b1;
		waitLeg(1'b0, 1'b1);
		chk("awake", sleepSt, 1'b0);
		outDis = 1'b1;
		repeat (5) @(negedge clk);
		chk("standby legs", {aHs, aLs, bHs, bLs}, 4'h0);
		chk("standby", standbySt, 1'b1);
		outDis = 1'b0;
		waitLeg(1'b0, 1'b1);
		chk("standby off", standbySt, 1'b0);
		$display("Bridge tests done");
		faults = 8'h01;
		repeat (5) @(negedge clk);
		chk("flag on", flagOe, 1'b1);
		chk("flag level", flagOut, 1'b0);
		host.xfer(16, 32'h0000_C000, rx);
		chk("config again", rx[15:0], 16'h0005);
		repeat (8) @(negedge clk);
		chk("flag masked", flagOe, 1'b0);
		faults = 8'h00;
		$display("Fault tests done");
		giveVerdict();
	end
endmodule
bind hbsc_top hbsc_checker #(.FAULT_W(FAULT_W)) u_chk (.clk(clk), .rstn(rstn), .spiClk(spiClk),
	.chip_select_n(chip_select_n), .mosi(mosi), .misoOut(misoOut), .misoOe(misoOe),
	.sleep_enable_in(sleep_enable_in), .output_disable_in(output_disable_in),
	.direction_in_a(direction_in_a), .direction_in_b(direction_in_b), .faultIn(faultIn),
	.bridge_out_a_hs(bridge_out_a_hs), .bridge_out_a_ls(bridge_out_a_ls), .bridge_out_b_hs(bridge_out_b_hs),
	.bridge_out_b_ls(bridge_out_b_ls), .sleepState(sleepState), .standbyState(standbyState),
	.slewSel(slewSel), .fault_flag_n_out(fault_flag_n_out), .fault_flag_n_oe(fault_flag_n_oe));
`default_nettype wire
